// file: core/shcfg_register_bank.sv
/*
  SMBus slave and byte-wide configuration register bank of a two-port hub controller.
  Assumes scl_i and sda_i are already synchronous to clk_i, and that the bus wire is
  resolved outside from sda_o and sda_oe_o (open drain, low only).
*/
module shcfg_register_bank #(
  parameter int TIMEOUT_CYCLES = shcfg_pkg::TIMEOUT_MIN_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic busy_o,
  output shcfg_pkg::shcfg_ident_t ident_o,
  output shcfg_pkg::shcfg_config_t cfg_o
);

  // The clock line is never an output, so this slave cannot stretch it.
  // No alert pin exists and the alert response address is never matched.

  logic [7:0] mem [0:255];
  shcfg_pkg::shcfg_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] ptr_reg;
  logic [5:0] remain_reg;
  logic rd_reg;
  logic cmd_seen_reg;
  logic master_ack_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic sda_oe_reg;
  logic sda_o_reg;
  logic busy_reg;
  logic [19:0] low_cnt_reg;
  shcfg_pkg::shcfg_ident_t ident_reg;
  shcfg_pkg::shcfg_config_t cfg_reg;

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic timeout;
  logic byte_done;
  logic wr_fire;
  logic [7:0] rd_data;

  // Writable and readable locations; everything else is reserved.
  function automatic logic is_mapped(input logic [7:0] addr);
    logic hit;
    hit = (addr <= shcfg_pkg::ADDR_BATTERY_CHARGE_ENABLE);
    if (addr == shcfg_pkg::ADDR_UPSTREAM_DRIVE_BOOST)
    begin
      hit = 1'b1;
    end
    else if (addr == shcfg_pkg::ADDR_DOWNSTREAM_DRIVE_BOOST)
    begin
      hit = 1'b1;
    end
    else if (addr == shcfg_pkg::ADDR_PORT_LINE_SWAP || addr == shcfg_pkg::ADDR_PORT_NUMBER_REMAP)
    begin
      hit = 1'b1;
    end
    else if (addr == shcfg_pkg::ADDR_STATUS_COMMAND)
    begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  assign scl_rise = scl_i & ~scl_prev_reg;
  assign scl_fall = ~scl_i & scl_prev_reg;
  assign start_det = scl_i & scl_prev_reg & sda_prev_reg & ~sda_i;
  assign stop_det = scl_i & scl_prev_reg & ~sda_prev_reg & sda_i;
  assign timeout = (low_cnt_reg >= 20'(TIMEOUT_CYCLES));
  assign byte_done = scl_fall & (bit_cnt_reg == 4'h8);
  assign wr_fire = (state_reg == shcfg_pkg::SHCFG_WDATA) & byte_done & (remain_reg != 6'h00);
  // Only loaded contents are visible; reserved locations read as zero.
  assign rd_data = is_mapped(ptr_reg) ? mem[ptr_reg] : 8'h00;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      scl_prev_reg <= scl_i;
      sda_prev_reg <= sda_i;
    end
  end

  // Counts only while a transfer is open, so an idle bus parked low does no harm.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      low_cnt_reg <= 20'h00000;
    end
    else if (scl_i || state_reg == shcfg_pkg::SHCFG_IDLE || timeout)
    begin
      low_cnt_reg <= 20'h00000;
    end
    else
    begin
      low_cnt_reg <= low_cnt_reg + 20'h00001;
    end
  end

  // Every location clears to zero; the built-in defaults are never loaded here.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 256; i++)
      begin
        mem[i] <= shcfg_pkg::REG_RESET;
      end
    end
    else if (wr_fire && is_mapped(ptr_reg))
    begin
      // Byte-wide storage for every documented register and text array.
      mem[ptr_reg] <= shift_reg;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ident_reg <= '0;
      cfg_reg <= '0;
    end
    else
    begin
      // Lower address supplies the low byte of each identifier.
      ident_reg.vendor_id <= {mem[shcfg_pkg::ADDR_VENDOR_ID_HIGH], mem[shcfg_pkg::ADDR_VENDOR_ID_LOW]};
      ident_reg.product_id <= {mem[shcfg_pkg::ADDR_PRODUCT_ID_HIGH], mem[shcfg_pkg::ADDR_PRODUCT_ID_LOW]};
      ident_reg.release_number <= {mem[shcfg_pkg::ADDR_RELEASE_NUMBER_HIGH],
                                   mem[shcfg_pkg::ADDR_RELEASE_NUMBER_LOW]};
      cfg_reg.config_byte_one <= mem[shcfg_pkg::ADDR_CONFIG_BYTE_ONE];
      cfg_reg.config_byte_two <= mem[shcfg_pkg::ADDR_CONFIG_BYTE_TWO];
      cfg_reg.config_byte_three <= mem[shcfg_pkg::ADDR_CONFIG_BYTE_THREE];
      cfg_reg.non_removable_ports <= mem[shcfg_pkg::ADDR_NON_REMOVABLE_PORTS];
      cfg_reg.port_disable_self_powered <= mem[shcfg_pkg::ADDR_PORT_DISABLE_SELF_POWERED];
      cfg_reg.port_disable_bus_powered <= mem[shcfg_pkg::ADDR_PORT_DISABLE_BUS_POWERED];
      cfg_reg.battery_charge_enable <= mem[shcfg_pkg::ADDR_BATTERY_CHARGE_ENABLE];
      cfg_reg.status_command <= mem[shcfg_pkg::ADDR_STATUS_COMMAND];
    end
  end

  // Bus protocol engine: bits are sampled on SCL rise and driven on SCL fall.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= shcfg_pkg::SHCFG_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      remain_reg <= 6'h00;
      rd_reg <= 1'b0;
      cmd_seen_reg <= 1'b0;
      master_ack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end
    else if (timeout)
    begin
      state_reg <= shcfg_pkg::SHCFG_IDLE;
      sda_oe_reg <= 1'b0;
      cmd_seen_reg <= 1'b0;
    end
    else if (stop_det)
    begin
      // A STOP always closes the transfer, including one right after START.
      state_reg <= shcfg_pkg::SHCFG_IDLE;
      sda_oe_reg <= 1'b0;
      cmd_seen_reg <= 1'b0;
    end
    else if (start_det)
    begin
      // A repeated START keeps the register pointer for the read direction.
      state_reg <= shcfg_pkg::SHCFG_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
      if (state_reg == shcfg_pkg::SHCFG_IDLE)
      begin
        cmd_seen_reg <= 1'b0;
      end
    end
    else
    begin
      case (state_reg)
        shcfg_pkg::SHCFG_ADDR, shcfg_pkg::SHCFG_CMD, shcfg_pkg::SHCFG_CNT, shcfg_pkg::SHCFG_WDATA:
        begin
          if (scl_rise && bit_cnt_reg != 4'h8)
          begin
            shift_reg <= {shift_reg[6:0], sda_i};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          else if (byte_done)
          begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == shcfg_pkg::SHCFG_ADDR)
            begin
              // General call and foreign addresses get no acknowledge.
              if (shift_reg[7:1] == shcfg_pkg::SLAVE_ADDR && (!shift_reg[0] || cmd_seen_reg))
              begin
                rd_reg <= shift_reg[0];
                sda_oe_reg <= 1'b1;
                state_reg <= shcfg_pkg::SHCFG_ACK_ADDR;
              end
              else
              begin
                state_reg <= shcfg_pkg::SHCFG_WAIT;
              end
            end
            else if (state_reg == shcfg_pkg::SHCFG_CMD)
            begin
              ptr_reg <= shift_reg;
              cmd_seen_reg <= 1'b1;
              sda_oe_reg <= 1'b1;
              state_reg <= shcfg_pkg::SHCFG_ACK_CMD;
            end
            else if (state_reg == shcfg_pkg::SHCFG_CNT)
            begin
              // A zero or oversized count is refused and nothing is written.
              if (shift_reg != 8'h00 && shift_reg <= shcfg_pkg::MAX_BYTE_COUNT)
              begin
                remain_reg <= shift_reg[5:0];
                sda_oe_reg <= 1'b1;
                state_reg <= shcfg_pkg::SHCFG_ACK_CNT;
              end
              else
              begin
                state_reg <= shcfg_pkg::SHCFG_WAIT;
              end
            end
            else if (remain_reg != 6'h00)
            begin
              ptr_reg <= ptr_reg + 8'h01;
              remain_reg <= remain_reg - 6'h01;
              sda_oe_reg <= 1'b1;
              state_reg <= shcfg_pkg::SHCFG_ACK_WDATA;
            end
            else
            begin
              // Bytes beyond the announced count are refused.
              state_reg <= shcfg_pkg::SHCFG_WAIT;
            end
          end
        end
        shcfg_pkg::SHCFG_ACK_ADDR:
        begin
          if (scl_fall)
          begin
            bit_cnt_reg <= 4'h0;
            if (rd_reg)
            begin
              // Block read opens with the byte count sent by the slave.
              shift_reg <= shcfg_pkg::READ_BYTE_COUNT;
              sda_oe_reg <= ~shcfg_pkg::READ_BYTE_COUNT[7];
              state_reg <= shcfg_pkg::SHCFG_TDATA;
            end
            else
            begin
              sda_oe_reg <= 1'b0;
              state_reg <= shcfg_pkg::SHCFG_CMD;
            end
          end
        end
        shcfg_pkg::SHCFG_ACK_CMD:
        begin
          if (scl_fall)
          begin
            sda_oe_reg <= 1'b0;
            state_reg <= shcfg_pkg::SHCFG_CNT;
          end
        end
        shcfg_pkg::SHCFG_ACK_CNT, shcfg_pkg::SHCFG_ACK_WDATA:
        begin
          if (scl_fall)
          begin
            sda_oe_reg <= 1'b0;
            state_reg <= shcfg_pkg::SHCFG_WDATA;
          end
        end
        shcfg_pkg::SHCFG_TDATA:
        begin
          if (scl_rise && bit_cnt_reg != 4'h8)
          begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          else if (byte_done)
          begin
            bit_cnt_reg <= 4'h0;
            sda_oe_reg <= 1'b0;
            state_reg <= shcfg_pkg::SHCFG_MACK;
          end
          else if (scl_fall)
          begin
            // Open drain: the line is pulled low only for a zero bit, MSB first.
            sda_oe_reg <= ~shift_reg[3'(4'h7 - bit_cnt_reg)];
          end
        end
        shcfg_pkg::SHCFG_MACK:
        begin
          if (scl_rise)
          begin
            master_ack_reg <= ~sda_i;
          end
          else if (scl_fall)
          begin
            if (master_ack_reg)
            begin
              shift_reg <= rd_data;
              ptr_reg <= ptr_reg + 8'h01;
              sda_oe_reg <= ~rd_data[7];
              state_reg <= shcfg_pkg::SHCFG_TDATA;
            end
            else
            begin
              state_reg <= shcfg_pkg::SHCFG_WAIT;
            end
          end
        end
        default:
        begin
          // Idle or waiting for the next START or STOP with the line released.
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // The data output only ever carries a zero; sda_oe_o alone decides whether the line is pulled.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sda_o_reg <= 1'b0;
    end
    else
    begin
      sda_o_reg <= 1'b0;
    end
  end

  // Busy trails the engine by one cycle so that the output comes straight from a flip-flop.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      busy_reg <= 1'b0;
    end
    else
    begin
      busy_reg <= (state_reg != shcfg_pkg::SHCFG_IDLE);
    end
  end

  assign sda_o = sda_o_reg;
  assign sda_oe_o = sda_oe_reg;
  assign busy_o = busy_reg;
  assign ident_o = ident_reg;
  assign cfg_o = cfg_reg;

endmodule

// file: core/shcfg_pkg.sv
/*
  Constants, register map and output carriers of the hub configuration register bank
  reached over its slave-only SMBus port.
  Assumes a single 10 MHz core clock and a synchronous active-high reset.
*/
package shcfg_pkg;

  localparam logic [6:0] SLAVE_ADDR = 7'h2C;
  localparam logic [7:0] MAX_BYTE_COUNT = 8'h20;
  localparam logic [7:0] READ_BYTE_COUNT = 8'h20;

  localparam int CLK_HZ = 10_000_000;
  localparam int TIMEOUT_MIN_MS = 25;
  localparam int TIMEOUT_MAX_MS = 35;
  localparam int TIMEOUT_MIN_CYCLES = TIMEOUT_MIN_MS * (CLK_HZ / 1000);
  localparam int TIMEOUT_MAX_CYCLES = TIMEOUT_MAX_MS * (CLK_HZ / 1000);

  localparam logic [7:0] REG_RESET = 8'h00;

  localparam logic [7:0] ADDR_VENDOR_ID_LOW = 8'h00;
  localparam logic [7:0] ADDR_VENDOR_ID_HIGH = 8'h01;
  localparam logic [7:0] ADDR_PRODUCT_ID_LOW = 8'h02;
  localparam logic [7:0] ADDR_PRODUCT_ID_HIGH = 8'h03;
  localparam logic [7:0] ADDR_RELEASE_NUMBER_LOW = 8'h04;
  localparam logic [7:0] ADDR_RELEASE_NUMBER_HIGH = 8'h05;
  localparam logic [7:0] ADDR_CONFIG_BYTE_ONE = 8'h06;
  localparam logic [7:0] ADDR_CONFIG_BYTE_TWO = 8'h07;
  localparam logic [7:0] ADDR_CONFIG_BYTE_THREE = 8'h08;
  localparam logic [7:0] ADDR_NON_REMOVABLE_PORTS = 8'h09;
  localparam logic [7:0] ADDR_PORT_DISABLE_SELF_POWERED = 8'h0A;
  localparam logic [7:0] ADDR_PORT_DISABLE_BUS_POWERED = 8'h0B;
  localparam logic [7:0] ADDR_MAX_POWER_SELF_POWERED = 8'h0C;
  localparam logic [7:0] ADDR_MAX_POWER_BUS_POWERED = 8'h0D;
  localparam logic [7:0] ADDR_HUB_CURRENT_SELF_POWERED = 8'h0E;
  localparam logic [7:0] ADDR_HUB_CURRENT_BUS_POWERED = 8'h0F;
  localparam logic [7:0] ADDR_PORT_POWER_ON_TIME = 8'h10;
  localparam logic [7:0] ADDR_LANGUAGE_ID_HIGH = 8'h11;
  localparam logic [7:0] ADDR_LANGUAGE_ID_LOW = 8'h12;
  localparam logic [7:0] ADDR_MAKER_TEXT_LENGTH = 8'h13;
  localparam logic [7:0] ADDR_PRODUCT_TEXT_LENGTH = 8'h14;
  localparam logic [7:0] ADDR_SERIAL_TEXT_LENGTH = 8'h15;
  localparam logic [7:0] ADDR_MAKER_TEXT_BYTES = 8'h16;
  localparam logic [7:0] ADDR_PRODUCT_TEXT_BYTES = 8'h54;
  localparam logic [7:0] ADDR_SERIAL_TEXT_BYTES = 8'h92;
  localparam logic [7:0] ADDR_SERIAL_TEXT_LAST = 8'hCF;
  localparam logic [7:0] ADDR_BATTERY_CHARGE_ENABLE = 8'hD0;
  localparam logic [7:0] ADDR_UPSTREAM_DRIVE_BOOST = 8'hF6;
  localparam logic [7:0] ADDR_DOWNSTREAM_DRIVE_BOOST = 8'hF8;
  localparam logic [7:0] ADDR_PORT_LINE_SWAP = 8'hFA;
  localparam logic [7:0] ADDR_PORT_NUMBER_REMAP = 8'hFB;
  localparam logic [7:0] ADDR_STATUS_COMMAND = 8'hFF;

  typedef struct packed {
    logic [15:0] vendor_id;
    logic [15:0] product_id;
    logic [15:0] release_number;
  } shcfg_ident_t;

  typedef struct packed {
    logic [7:0] config_byte_one;
    logic [7:0] config_byte_two;
    logic [7:0] config_byte_three;
    logic [7:0] non_removable_ports;
    logic [7:0] port_disable_self_powered;
    logic [7:0] port_disable_bus_powered;
    logic [7:0] battery_charge_enable;
    logic [7:0] status_command;
  } shcfg_config_t;

  typedef enum logic [3:0] {
    SHCFG_IDLE = 4'h0,
    SHCFG_ADDR = 4'h1,
    SHCFG_ACK_ADDR = 4'h3,
    SHCFG_CMD = 4'h2,
    SHCFG_ACK_CMD = 4'h6,
    SHCFG_CNT = 4'h7,
    SHCFG_ACK_CNT = 4'h5,
    SHCFG_WDATA = 4'h4,
    SHCFG_ACK_WDATA = 4'hC,
    SHCFG_TDATA = 4'hD,
    SHCFG_MACK = 4'hF,
    SHCFG_WAIT = 4'hE
  } shcfg_state_t;

endpackage

// file: tb/shcfg_assertions.sv
/*
  Port-level concurrent checks for the hub configuration register bank.
  Assumes one clock domain, a synchronous active-high reset and a bench that binds it here.
*/
module shcfg_assertions #(
  parameter int TIMEOUT_CYCLES = 200
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic busy_o,
  input wire shcfg_pkg::shcfg_ident_t ident_o,
  input wire shcfg_pkg::shcfg_config_t cfg_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  int low_cnt;
  // The count saturates so the timeout check fires once per long low phase.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || scl_i)
    begin
      low_cnt <= 0;
    end
    else if (low_cnt < TIMEOUT_CYCLES + 8)
    begin
      low_cnt <= low_cnt + 1;
    end
  end
  a_sda_low_only: assert property (sda_o == 1'b0) else $error("data output not low");
  a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i))
    else $error("data pull changed while clock high");
  a_ack_stands: assert property ($rose(sda_oe_o) |-> sda_oe_o[*5]) else $error("data pull too short");
  a_idle_quiet: assert property (!busy_o |-> !sda_oe_o) else $error("data pulled while idle");
  a_stop_idles: assert property ($rose(sda_i) && scl_i && $past(scl_i) |-> ##[1:3] !busy_o)
    else $error("no idle after stop");
  a_start_busy: assert property ($fell(sda_i) && scl_i && $past(scl_i) |-> ##[1:3] busy_o)
    else $error("no busy after start");
  a_timeout_idle: assert property (low_cnt == TIMEOUT_CYCLES + 4 |-> !busy_o && !sda_oe_o)
    else $error("no reset after clock low timeout");
  a_cfg_on_ack: assert property ($changed(cfg_o) |-> sda_oe_o && busy_o)
    else $error("config changed without ack");
  a_ident_on_ack: assert property ($changed(ident_o) |-> sda_oe_o && busy_o)
    else $error("identity changed without ack");
endmodule

bind shcfg_register_bank shcfg_assertions #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_shcfg_assertions (
  .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .busy_o(busy_o), .ident_o(ident_o), .cfg_o(cfg_o));

// file: tb/shcfg_host_model.sv
/*
  SMBus host model that loads and reads back the register bank.
  Assumes the bench resolves the pulled-up data wire and that all changes follow falling clock edges.
*/
module shcfg_host_model (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Data moves only while the clock is low, so no false START or STOP is seen.
  task automatic bit_io(input logic b, output logic r);
    sda_o = b;
    tick(2);
    scl_o = 1'b1;
    tick(2);
    r = sda_i;
    tick(2);
    scl_o = 1'b0;
    tick(1);
  endtask
  task automatic start_cond();
    sda_o = 1'b1;
    tick(1);
    scl_o = 1'b1;
    tick(2);
    sda_o = 1'b0;
    tick(2);
    scl_o = 1'b0;
    tick(1);
  endtask
  task automatic stop_cond();
    sda_o = 1'b0;
    tick(1);
    scl_o = 1'b1;
    tick(2);
    sda_o = 1'b1;
    tick(2);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic recv(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, d[i]);
    end
    bit_io(~ack, r);
  endtask
  // Stops at the first refused byte; n_ack counts the bytes taken.
  task automatic block_write(input logic [7:0] sa, cmd, cnt, input logic [7:0] d[$], output logic [7:0] n_ack);
    logic [7:0] q[$];
    logic ack;
    q = {sa, cmd, cnt, d};
    n_ack = 8'h00;
    start_cond();
    foreach (q[i])
    begin
      send(q[i], ack);
      if (!ack)
      begin
        break;
      end
      n_ack++;
    end
    stop_cond();
  endtask
  task automatic block_read(input logic [7:0] cmd, input int k, output logic [7:0] cnt, output logic [7:0] d[$]);
    logic ack;
    logic [7:0] b;
    d = {};
    start_cond();
    send({shcfg_pkg::SLAVE_ADDR, 1'b0}, ack);
    send(cmd, ack);
    start_cond();
    send({shcfg_pkg::SLAVE_ADDR, 1'b1}, ack);
    recv(1'b1, cnt);
    for (int i = 0; i < k; i++)
    begin
      recv(i < k - 1, b);
      d.push_back(b);
    end
    stop_cond();
  endtask
endmodule

// file: tb/tb_shcfg_register_bank.sv
/*
  Self-checking bench for the hub configuration register bank.
  Assumes a 10 MHz clock and a slave timeout shortened to 200 cycles.
*/
`define CHECK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("wrong value at %0t: got %0h, expected %0h", $time, got, exp); \
    end \
  end

module tb_shcfg_register_bank;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TMO = 200;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic scl, host_sda, sda_o, sda_oe_o, busy_o, ack, sda_wire;
  shcfg_pkg::shcfg_ident_t ident_o;
  shcfg_pkg::shcfg_config_t cfg_o;
  int n_mismatch = 0;
  int checked = 0;
  logic [7:0] n_ack, cnt, b;
  logic [7:0] d[$];
  logic [7:0] ref_sa[6] = '{8'h5A, 8'h00, 8'h58, 8'h58, 8'h58, 8'h59};
  logic [7:0] ref_cmd[6] = '{8'h06, 8'h06, 8'h06, 8'h06, 8'h07, 8'h06};
  logic [7:0] ref_cnt[6] = '{8'h01, 8'h01, 8'h00, 8'h21, 8'h01, 8'h01};
  logic [7:0] ref_ack[6] = '{8'h00, 8'h00, 8'h02, 8'h02, 8'h04, 8'h00};

  always #50 clk_i = ~clk_i;
  assign sda_wire = host_sda & (sda_oe_o ? sda_o : 1'b1);

  shcfg_register_bank #(.TIMEOUT_CYCLES(TMO)) i_shcfg_register_bank (.clk_i(clk_i), .rst_i(rst_i),
    .scl_i(scl), .sda_i(sda_wire), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .busy_o(busy_o), .ident_o(ident_o),
    .cfg_o(cfg_o));
  shcfg_host_model i_shcfg_host_model (.clk_i(clk_i), .sda_i(sda_wire), .scl_o(scl), .sda_o(host_sda));

  function automatic logic [7:0] pat(input logic [7:0] a);
    return a + 8'h11;
  endfunction
  function automatic logic rsv(input logic [7:0] a);
    return (a > 8'hD0 && a < 8'hF6) || a == 8'hF7 || a == 8'hF9 || (a > 8'hFB && a < 8'hFF);
  endfunction

  task automatic give_verdict();
    if (n_mismatch == 0 && checked > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial
  begin
    #8_000_000;
    n_mismatch++;
    give_verdict();
  end

  initial
  begin
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    `CHECK({busy_o, sda_oe_o}, 2'h0)
    `CHECK(ident_o, 48'h0)
    `CHECK(cfg_o, 64'h0)
    for (int blk = 0; blk < 8; blk++)
    begin
      d = {};
      for (int i = 0; i < 32; i++)
      begin
        d.push_back(pat(8'(blk * 32 + i)));
      end
      i_shcfg_host_model.block_write(8'h58, 8'(blk * 32), 8'h20, d, n_ack);
      `CHECK(n_ack, 8'h23)
    end
    `CHECK(ident_o, {pat(8'h01), pat(8'h00), pat(8'h03), pat(8'h02), pat(8'h05), pat(8'h04)})
    `CHECK(cfg_o[63:32], {pat(8'h06), pat(8'h07), pat(8'h08), pat(8'h09)})
    `CHECK(cfg_o[31:0], {pat(8'h0A), pat(8'h0B), pat(8'hD0), pat(8'hFF)})
    for (int blk = 0; blk < 8; blk++)
    begin
      i_shcfg_host_model.block_read(8'(blk * 32), 32, cnt, d);
      `CHECK(cnt, shcfg_pkg::READ_BYTE_COUNT)
      foreach (d[i])
      begin
        b = 8'(blk * 32 + i);
        `CHECK(d[i], rsv(b) ? 8'h00 : pat(b))
      end
    end
    d = {8'h77, 8'h66};
    foreach (ref_sa[i])
    begin
      i_shcfg_host_model.block_write(ref_sa[i], ref_cmd[i], ref_cnt[i], d, n_ack);
      `CHECK(n_ack, ref_ack[i])
    end
    i_shcfg_host_model.block_read(8'h06, 3, cnt, d);
    `CHECK({d[0], d[1], d[2]}, {pat(8'h06), 8'h77, pat(8'h08)})
    // A repeated START followed at once by STOP must return the slave to idle.
    i_shcfg_host_model.start_cond();
    i_shcfg_host_model.send(8'h58, ack);
    i_shcfg_host_model.send(8'h09, ack);
    i_shcfg_host_model.start_cond();
    i_shcfg_host_model.stop_cond();
    repeat (3) @(negedge clk_i);
    `CHECK(busy_o, 1'b0)
    i_shcfg_host_model.start_cond();
    i_shcfg_host_model.send(8'h58, ack);
    `CHECK(busy_o, 1'b1)
    repeat (TMO + 5) @(negedge clk_i);
    `CHECK({busy_o, sda_oe_o}, 2'h0)
    i_shcfg_host_model.stop_cond();
    d = {8'hA1};
    i_shcfg_host_model.block_write(8'h58, 8'h09, 8'h01, d, n_ack);
    `CHECK({n_ack, cfg_o.non_removable_ports}, {8'h04, 8'hA1})
    // Two reset cycles keep the change of the outputs inside the disabled window of the checks.
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    `CHECK({ident_o, cfg_o}, 112'h0)
    i_shcfg_host_model.block_read(8'h09, 1, cnt, d);
    `CHECK(d[0], 8'h00)
    give_verdict();
  end
endmodule
